// ===== wreg_pkg.sv
// shared constants, types and decode helpers for working-register addressing
package wreg_pkg;

  // ---------------------------------------------------------------------
  // register-file offsets and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] PTR_LO_ADDR   = 8'hd6;
  localparam logic [7:0] PTR_HI_ADDR   = 8'hd7;
  localparam logic [7:0] PTR_LO_RESET  = 8'hc0;
  localparam logic [7:0] PTR_HI_RESET  = 8'hc8;
  localparam logic [7:0] UPPER_BASE    = 8'hc0;  // set 1 / set 2 start
  localparam logic [7:0] COMMON_END    = 8'hcf;  // last common-area byte
  localparam logic [7:0] SLICE_STEP    = 8'h08;  // bytes in one slice

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int FIELD_SEL_BIT  = 3;  // picks the pointer
  localparam int FIELD_IDX_MSB  = 2;  // register index inside a slice
  localparam int PTR_SLICE_MSB  = 7;
  localparam int PTR_SLICE_LSB  = 3;
  localparam int PAIR_BIT       = 0;  // low address bit of a pair

  // ---------------------------------------------------------------------
  // operand modes and pointer-set operations
  // ---------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_WORKING  = 2'b00,
    MODE_DIRECT   = 2'b01,
    MODE_INDIRECT = 2'b10,
    MODE_INDEXED  = 2'b11
  } addr_mode_type;

  typedef enum logic [1:0]
  {
    PTR_OP_NONE   = 2'b00,
    set_both_pointers_op = 2'b01,
    set_low_pointer_op   = 2'b10,
    set_high_pointer_op  = 2'b11
  } ptr_op_type;

  // set-1 location of the low pointer
  function automatic logic is_lo_ptr(input logic [7:0] a, input logic s2);
    return !s2 && (a == PTR_LO_ADDR);
  endfunction : is_lo_ptr

  // set-1 location of the high pointer
  function automatic logic is_hi_ptr(input logic [7:0] a, input logic s2);
    return !s2 && (a == PTR_HI_ADDR);
  endfunction : is_hi_ptr

endpackage : wreg_pkg

// ===== resolve_if.sv
// carrier between the pointer registers and the address resolver
interface resolve_if;
  import wreg_pkg::*;

  logic [7:0]    ptr_lo;
  logic [7:0]    ptr_hi;
  addr_mode_type mode;
  logic [7:0]    field;
  logic          pair;
  logic [7:0]    addr;
  logic          set2;
  logic          pair_err;
  logic          form_err;

  // pointer owner drives the request side
  modport ctrl (output ptr_lo, ptr_hi, mode, field, pair,
                input  addr, set2, pair_err, form_err);

  // resolver computes the physical address
  modport calc (input  ptr_lo, ptr_hi, mode, field, pair,
                output addr, set2, pair_err, form_err);

endinterface : resolve_if

// ===== addr_resolver.sv
// combinational operand address resolver
module addr_resolver
  import wreg_pkg::*;
(
  // request and result
  resolve_if.calc rif
);

  logic [7:0] chosen_ptr;
  logic       pair_odd;

  // -----------------------------------------------------------------------
  // pointer choice and slice concatenation
  // -----------------------------------------------------------------------
  // a swapped or scattered pair of slices is honoured as written
  assign chosen_ptr = rif.field[FIELD_SEL_BIT] ? rif.ptr_hi
                                               : rif.ptr_lo;
  assign pair_odd   = rif.pair && rif.field[PAIR_BIT];

  // -----------------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------------
  // no page input: the working result never depends on the page
  always_comb
  begin
    rif.addr     = rif.field;
    rif.set2     = 1'b0;
    rif.pair_err = pair_odd;  // pairs start on an even byte
    rif.form_err = 1'b0;
    unique case (rif.mode)
      MODE_WORKING:
      begin
        // pointer low bits are dropped; only the slice bits count
        rif.addr = {chosen_ptr[PTR_SLICE_MSB:PTR_SLICE_LSB],
                    rif.field[FIELD_IDX_MSB:0]};
        rif.set2 = 1'b0;  // working access stays out of set 2
      end
      MODE_DIRECT:
      begin
        rif.set2     = 1'b0;  // upper range means set 1 here
        rif.form_err = (rif.field >= UPPER_BASE) &&
                       (rif.field <= COMMON_END);
      end
      MODE_INDIRECT,
      MODE_INDEXED:
      begin
        rif.set2 = (rif.field >= UPPER_BASE);  // only path to set 2
      end
    endcase
  end

endmodule : addr_resolver

// ===== working_register_address_gen.sv
// working-slice pointers and operand address generation
module working_register_address_gen
  import wreg_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // set-pointer instruction
  input  wire logic          set_valid,
  input  wire ptr_op_type    set_op,
  input  wire logic [7:0]    set_imm,
  // register-file write port from the datapath (load_op and others)
  input  wire logic          rf_we,
  input  wire logic [7:0]    rf_waddr,
  input  wire logic          rf_wset2,
  input  wire logic [7:0]    rf_wdata,
  // register-file read port
  input  wire logic [7:0]    rf_raddr,
  input  wire logic          rf_rset2,
  output logic      [7:0]    rd_data_r,
  output logic               rd_hit_r,
  // operand request from the decoder
  input  wire logic          op_valid,
  input  wire addr_mode_type op_mode,
  input  wire logic [7:0]    op_field,
  input  wire logic          op_pair,
  input  wire logic [15:0]   op_wdata,
  // resolved operand
  output logic               res_valid_r,
  output logic      [7:0]    res_addr_r,
  output logic      [7:0]    res_odd_addr_r,
  output logic               res_set2_r,
  output logic               res_pair_err_r,
  output logic               res_form_err_r,
  output logic      [7:0]    even_data_r,
  output logic      [7:0]    odd_data_r,
  // current pointers
  output logic      [7:0]    ptr_lo_r,
  output logic      [7:0]    ptr_hi_r
);

  resolve_if rif ();

  logic set_lo;
  logic set_hi;
  logic wr_lo;
  logic wr_hi;

  // -----------------------------------------------------------------------
  // address resolver
  // -----------------------------------------------------------------------
  assign rif.ptr_lo = ptr_lo_r;
  assign rif.ptr_hi = ptr_hi_r;
  assign rif.mode   = op_mode;
  assign rif.field  = op_field;
  assign rif.pair   = op_pair;

  addr_resolver u_resolver
  (
    .rif (rif.calc)
  );

  // -----------------------------------------------------------------------
  // pointer write decode
  // -----------------------------------------------------------------------
  // a set-pointer op and a register write in one cycle: the op wins
  assign set_lo = set_valid && ((set_op == set_both_pointers_op) ||
                                (set_op == set_low_pointer_op));
  assign set_hi = set_valid && ((set_op == set_both_pointers_op) ||
                                (set_op == set_high_pointer_op));
  assign wr_lo  = rf_we && is_lo_ptr(rf_waddr, rf_wset2);
  assign wr_hi  = rf_we && is_hi_ptr(rf_waddr, rf_wset2);

  // -----------------------------------------------------------------------
  // pointer registers
  // -----------------------------------------------------------------------
  // low pointer; new value is seen by the following access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_lo_r <= PTR_LO_RESET;
    else if (set_lo)
      ptr_lo_r <= set_imm;
    else if (wr_lo)
      ptr_lo_r <= rf_wdata;
  end

  // high pointer; the combined op adds one slice and wraps at 8 bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_hi_r <= PTR_HI_RESET;
    else if (set_hi)
      ptr_hi_r <= (set_op == set_both_pointers_op)
                  ? 8'(set_imm + SLICE_STEP) : set_imm;
    else if (wr_hi)
      ptr_hi_r <= rf_wdata;
  end

  // -----------------------------------------------------------------------
  // pointer read-back
  // -----------------------------------------------------------------------
  // other addresses answer zero with the hit flag low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_r <= 8'h00;
      rd_hit_r  <= 1'b0;
    end
    else if (is_lo_ptr(rf_raddr, rf_rset2))
    begin
      rd_data_r <= ptr_lo_r;
      rd_hit_r  <= 1'b1;
    end
    else if (is_hi_ptr(rf_raddr, rf_rset2))
    begin
      rd_data_r <= ptr_hi_r;
      rd_hit_r  <= 1'b1;
    end
    else
    begin
      rd_data_r <= 8'h00;
      rd_hit_r  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // resolved operand
  // -----------------------------------------------------------------------
  // valid is a one-cycle pulse per request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      res_valid_r <= 1'b0;
    else
      res_valid_r <= op_valid;
  end

  // address and flags hold until the next request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_addr_r     <= 8'h00;
      res_odd_addr_r <= 8'h00;
      res_set2_r     <= 1'b0;
      res_pair_err_r <= 1'b0;
      res_form_err_r <= 1'b0;
    end
    else if (op_valid)
    begin
      res_addr_r     <= rif.addr;
      res_odd_addr_r <= rif.addr | 8'h01;
      res_set2_r     <= rif.set2;
      res_pair_err_r <= rif.pair_err;
      res_form_err_r <= rif.form_err;
    end
  end

  // pair byte order: high byte to the even register, low to the odd
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      even_data_r <= 8'h00;
      odd_data_r  <= 8'h00;
    end
    else if (op_valid)
    begin
      even_data_r <= op_wdata[15:8];
      odd_data_r  <= op_wdata[7:0];
    end
  end

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  sequence s_load_low;
    set_valid && (set_op == set_low_pointer_op);
  endsequence

  sequence s_work_low_access;
    op_valid && (op_mode == MODE_WORKING) && !op_field[FIELD_SEL_BIT];
  endsequence

  property p_reset_values;
    @(posedge clk) disable iff (rst)
    $past(rst) |-> (ptr_lo_r == PTR_LO_RESET) &&
                   (ptr_hi_r == PTR_HI_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("pointer reset values wrong");

  property p_both_set;
    @(posedge clk) disable iff (rst)
    set_valid && (set_op == set_both_pointers_op) |=>
      (ptr_lo_r == $past(set_imm)) &&
      (ptr_hi_r == 8'($past(set_imm) + SLICE_STEP));
  endproperty
  a_both_set: assert property (p_both_set)
    else $error("combined set did not load both pointers");

  property p_low_only;
    @(posedge clk) disable iff (rst)
    set_valid && (set_op == set_low_pointer_op) && !wr_hi |=>
      $stable(ptr_hi_r) && (ptr_lo_r == $past(set_imm));
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("low set disturbed the high pointer");

  property p_reg_write;
    @(posedge clk) disable iff (rst)
    rf_we && !rf_wset2 && (rf_waddr == PTR_HI_ADDR) && !set_valid |=>
      ptr_hi_r == $past(rf_wdata);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("register write missed the high pointer");

  property p_next_access;
    @(posedge clk) disable iff (rst)
    (s_load_low ##1 s_work_low_access) |=>
      res_addr_r[PTR_SLICE_MSB:PTR_SLICE_LSB] ==
        $past(set_imm[PTR_SLICE_MSB:PTR_SLICE_LSB], 2);
  endproperty
  a_next_access: assert property (p_next_access)
    else $error("access after load used the old pointer");

  property p_work_addr;
    @(posedge clk) disable iff (rst)
    op_valid && (op_mode == MODE_WORKING) |=>
      res_addr_r == ($past(op_field[FIELD_SEL_BIT])
        ? {$past(ptr_hi_r[PTR_SLICE_MSB:PTR_SLICE_LSB]),
           $past(op_field[FIELD_IDX_MSB:0])}
        : {$past(ptr_lo_r[PTR_SLICE_MSB:PTR_SLICE_LSB]),
           $past(op_field[FIELD_IDX_MSB:0])});
  endproperty
  a_work_addr: assert property (p_work_addr)
    else $error("working address formed wrongly");

  property p_work_set1;
    @(posedge clk) disable iff (rst)
    op_valid && (op_mode == MODE_WORKING) |=> res_valid_r && !res_set2_r;
  endproperty
  a_work_set1: assert property (p_work_set1)
    else $error("working access reached set 2");

  property p_direct_set1;
    @(posedge clk) disable iff (rst)
    op_valid && (op_mode == MODE_DIRECT) |=>
      !res_set2_r && (res_addr_r == $past(op_field));
  endproperty
  a_direct_set1: assert property (p_direct_set1)
    else $error("direct access left set 1");

  property p_indirect_set2;
    @(posedge clk) disable iff (rst)
    op_valid && (op_mode != MODE_WORKING) && (op_mode != MODE_DIRECT) |=>
      res_set2_r == ($past(op_field) >= UPPER_BASE);
  endproperty
  a_indirect_set2: assert property (p_indirect_set2)
    else $error("indirect or indexed set 2 select wrong");

  property p_pair_even;
    @(posedge clk) disable iff (rst)
    op_valid |=> res_pair_err_r == ($past(op_pair) && $past(op_field[0]))
                 && (res_odd_addr_r == (res_addr_r | 8'h01));
  endproperty
  a_pair_even: assert property (p_pair_even)
    else $error("pair alignment flag or odd address wrong");

  property p_pair_order;
    @(posedge clk) disable iff (rst)
    op_valid && op_pair |=> (even_data_r == $past(op_wdata[15:8])) &&
                            (odd_data_r == $past(op_wdata[7:0]));
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("pair bytes in the wrong registers");

  property p_read_ptr;
    @(posedge clk) disable iff (rst)
    !rf_rset2 && (rf_raddr == PTR_LO_ADDR) |=>
      rd_hit_r && (rd_data_r == $past(ptr_lo_r));
  endproperty
  a_read_ptr: assert property (p_read_ptr)
    else $error("low pointer read-back wrong");

  property p_slice_bits_only;
    @(posedge clk) disable iff (rst)
    op_valid && (op_mode == MODE_WORKING) && !op_field[FIELD_SEL_BIT] |=>
      res_addr_r[FIELD_IDX_MSB:0] == $past(op_field[FIELD_IDX_MSB:0]);
  endproperty
  a_slice_bits_only: assert property (p_slice_bits_only)
    else $error("pointer low bits leaked into the address");

endmodule : working_register_address_gen

// ===== decoder_model.sv
// decoder and datapath model driving the request side of the block
module decoder_model
  import wreg_pkg::*;
(
  // clock
  input  wire logic    clk,
  // set-pointer instruction
  output logic          set_valid,
  output ptr_op_type    set_op,
  output logic [7:0]    set_imm,
  // register-file write and read
  output logic          rf_we,
  output logic [7:0]    rf_waddr,
  output logic          rf_wset2,
  output logic [7:0]    rf_wdata,
  output logic [7:0]    rf_raddr,
  output logic          rf_rset2,
  // operand request
  output logic          op_valid,
  output addr_mode_type op_mode,
  output logic [7:0]    op_field,
  output logic          op_pair,
  output logic [15:0]   op_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------
  // idle values at time zero
  // ---------------------------------------------------------------------
  initial
  begin
    {set_valid, rf_we, op_valid, rf_wset2, rf_rset2, op_pair} = '0;
    set_op   = PTR_OP_NONE;
    op_mode  = MODE_WORKING;
    {set_imm, rf_waddr, rf_wdata, rf_raddr, op_field} = '0;
    op_wdata = '0;
  end

  // any slice choice is passed on as given, swapped too
  task automatic put_set(input ptr_op_type op, input logic [7:0] imm);
    @(negedge clk);
    set_valid = 1'b1;
    set_op    = op;
    set_imm   = imm;
    @(negedge clk);
    set_valid = 1'b0;
    set_imm   = ~imm;  // released: stale data must not look valid
  endtask : put_set

  // load_op style register write
  task automatic put_wr(input logic [7:0] a, input logic s2,
                        input logic [7:0] d);
    @(negedge clk);
    rf_we    = 1'b1;
    rf_waddr = a;
    rf_wset2 = s2;
    rf_wdata = d;
    @(negedge clk);
    rf_we    = 1'b0;
    rf_wdata = ~d;
  endtask : put_wr

  // read answer is settled one cycle after the address
  task automatic put_rd(input logic [7:0] a, input logic s2);
    @(negedge clk);
    rf_raddr = a;
    rf_rset2 = s2;
    @(negedge clk);
  endtask : put_rd

  // common area normally sent only as working fields
  task automatic put_op(input addr_mode_type m, input logic [7:0] f,
                        input logic p, input logic [15:0] wd);
    @(negedge clk);
    op_valid = 1'b1;
    op_mode  = m;
    op_field = f;
    op_pair  = p;
    op_wdata = wd;
    @(negedge clk);
    op_valid = 1'b0;
    op_field = ~f;
    op_wdata = ~wd;
  endtask : put_op

  // low-pointer set with a working access to it on the very next edge
  task automatic put_set_op(input logic [7:0] imm, input logic [7:0] f);
    @(negedge clk);
    set_valid = 1'b1;
    set_op    = set_low_pointer_op;
    set_imm   = imm;
    @(negedge clk);
    set_valid = 1'b0;
    set_imm   = ~imm;
    op_valid  = 1'b1;
    op_mode   = MODE_WORKING;
    op_field  = f;
    op_pair   = 1'b0;
    @(negedge clk);
    op_valid  = 1'b0;
    op_field  = ~f;
  endtask : put_set_op
endmodule : decoder_model

// ===== working_register_address_gen_tb.sv
// self-checking bench for the working-register address generator
module working_register_address_gen_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wreg_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic set_valid, rf_we, rf_wset2, rf_rset2, op_valid, op_pair;
  ptr_op_type    set_op;
  addr_mode_type op_mode;
  logic [7:0]  set_imm, rf_waddr, rf_wdata, rf_raddr, op_field;
  logic [15:0] op_wdata;
  logic [7:0]  rd_data_r, res_addr_r, res_odd_addr_r;
  logic [7:0]  even_data_r, odd_data_r, ptr_lo_r, ptr_hi_r;
  logic rd_hit_r, res_valid_r, res_set2_r, res_pair_err_r, res_form_err_r;
  int num_errors = 0;
  int num_checks = 0;
  int cycles     = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  decoder_model i_dec (.clk(clk), .set_valid(set_valid), .set_op(set_op),
    .set_imm(set_imm), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wset2(rf_wset2), .rf_wdata(rf_wdata), .rf_raddr(rf_raddr),
    .rf_rset2(rf_rset2), .op_valid(op_valid), .op_mode(op_mode),
    .op_field(op_field), .op_pair(op_pair), .op_wdata(op_wdata));

  working_register_address_gen i_dut (.clk(clk), .rst(rst),
    .set_valid(set_valid), .set_op(set_op), .set_imm(set_imm),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wset2(rf_wset2),
    .rf_wdata(rf_wdata), .rf_raddr(rf_raddr), .rf_rset2(rf_rset2),
    .rd_data_r(rd_data_r), .rd_hit_r(rd_hit_r), .op_valid(op_valid),
    .op_mode(op_mode), .op_field(op_field), .op_pair(op_pair),
    .op_wdata(op_wdata), .res_valid_r(res_valid_r),
    .res_addr_r(res_addr_r), .res_odd_addr_r(res_odd_addr_r),
    .res_set2_r(res_set2_r), .res_pair_err_r(res_pair_err_r),
    .res_form_err_r(res_form_err_r), .even_data_r(even_data_r),
    .odd_data_r(odd_data_r), .ptr_lo_r(ptr_lo_r), .ptr_hi_r(ptr_hi_r));

  // ---------------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ptrs(input logic [7:0] lo, input logic [7:0] hi);
    chk(ptr_lo_r, lo);
    chk(ptr_hi_r, hi);
  endtask : ptrs

  // one single-byte operand and its resolved result
  task automatic op_chk(input addr_mode_type m, input logic [7:0] f,
                        input logic [7:0] a, input logic s2,
                        input logic fe);
    i_dec.put_op(m, f, 1'b0, 16'h0000);
    chk(8'(res_valid_r), 8'h01);
    chk(res_addr_r, a);
    chk(8'(res_set2_r), 8'(s2));
    chk(8'(res_form_err_r), 8'(fe));
  endtask : op_chk

  // hang guard: the whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    ptrs(8'hc0, 8'hc8);
    i_dec.put_rd(8'hd6, 1'b0);
    chk(rd_data_r, 8'hc0);
    chk(8'(rd_hit_r), 8'h01);
    for (int i = 0; i < 16; i++)
      op_chk(MODE_WORKING, 8'(i), 8'hc0 + 8'(i), 1'b0, 1'b0);
    i_dec.put_set(set_both_pointers_op, 8'h70);
    ptrs(8'h70, 8'h78);
    op_chk(MODE_WORKING, 8'h06, 8'h76, 1'b0, 1'b0);
    op_chk(MODE_WORKING, 8'h0e, 8'h7e, 1'b0, 1'b0);
    i_dec.put_set(set_high_pointer_op, 8'h48);
    ptrs(8'h70, 8'h48);
    i_dec.put_set(set_low_pointer_op, 8'ha0);
    ptrs(8'ha0, 8'h48);
    i_dec.put_set(PTR_OP_NONE, 8'h55);
    ptrs(8'ha0, 8'h48);
    i_dec.put_wr(8'hd7, 1'b0, 8'hf8);
    ptrs(8'ha0, 8'hf8);
    i_dec.put_wr(8'hd6, 1'b1, 8'h11);
    i_dec.put_wr(8'hd5, 1'b0, 8'h22);
    ptrs(8'ha0, 8'hf8);
    op_chk(MODE_WORKING, 8'h0f, 8'hff, 1'b0, 1'b0);
    i_dec.put_rd(8'hd7, 1'b0);
    chk(rd_data_r, 8'hf8);
    i_dec.put_rd(8'hd6, 1'b1);
    chk(8'(rd_hit_r), 8'h00);
    chk(rd_data_r, 8'h00);
    // swapped, non-contiguous slices with low pointer bits set
    i_dec.put_wr(8'hd6, 1'b0, 8'h3f);
    i_dec.put_wr(8'hd7, 1'b0, 8'h10);
    op_chk(MODE_WORKING, 8'h02, 8'h3a, 1'b0, 1'b0);
    op_chk(MODE_WORKING, 8'h0a, 8'h12, 1'b0, 1'b0);
    op_chk(MODE_DIRECT, 8'he5, 8'he5, 1'b0, 1'b0);
    op_chk(MODE_DIRECT, 8'hc2, 8'hc2, 1'b0, 1'b1);
    op_chk(MODE_INDIRECT, 8'he5, 8'he5, 1'b1, 1'b0);
    op_chk(MODE_INDEXED, 8'h40, 8'h40, 1'b0, 1'b0);
    op_chk(MODE_INDEXED, 8'hc0, 8'hc0, 1'b1, 1'b0);
    // register pairs: high byte to the even register
    i_dec.put_op(MODE_WORKING, 8'h04, 1'b1, 16'h1234);
    chk(res_addr_r, 8'h3c);
    chk(res_odd_addr_r, 8'h3d);
    chk(8'(res_pair_err_r), 8'h00);
    chk(even_data_r, 8'h12);
    chk(odd_data_r, 8'h34);
    i_dec.put_op(MODE_DIRECT, 8'h41, 1'b1, 16'habcd);
    chk(8'(res_pair_err_r), 8'h01);
    // a new low pointer is used by the access right behind it
    i_dec.put_set_op(8'h88, 8'h05);
    chk(8'(res_valid_r), 8'h01);
    chk(res_addr_r, 8'h8d);
    ptrs(8'h88, 8'h10);
    i_dec.put_set(set_both_pointers_op, 8'hf8);
    ptrs(8'hf8, 8'h00);
    // reset again in mid-run
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    ptrs(8'hc0, 8'hc8);
    final_report();
  end
endmodule : working_register_address_gen_tb
